//--- verilog/adc_result_filter.sv
// Result filter stage on result slots seven and fifteen of a converter group.
// Assumes conversions are synchronous to sys_clk and at least two cycles apart.
`timescale 1ns/1ps
`default_nettype none
module adc_result_filter
  import adc_result_filter_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  // conversion results
  input  wire conv_t             conv,
  // register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [31:0]       regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [31:0]       regRdData,
  // interrupt
  output logic                   irq
);

  // the register map needs five address bits
  if (ADDR_W < 5) begin : gBadAddrW
    $error("adc_result_filter: ADDR_W too small for the map");
  end

  // ==========================================================================
  // functions
  function automatic coeff_t firCoeff(input logic [3:0] code);
    coeff_t k;
    k = '{a: 2'd0, b: 2'd0, c: 2'd0};
    unique case (code)
      4'h0: k = '{a: 2'd2, b: 2'd1, c: 2'd0}; // R1
      4'h1: k = '{a: 2'd1, b: 2'd2, c: 2'd0}; // R1
      4'h2: k = '{a: 2'd2, b: 2'd0, c: 2'd1}; // R1
      4'h3: k = '{a: 2'd1, b: 2'd1, c: 2'd1}; // R1
      4'h4: k = '{a: 2'd1, b: 2'd0, c: 2'd2}; // R1
      4'h5: k = '{a: 2'd3, b: 2'd1, c: 2'd0}; // R2
      4'h6: k = '{a: 2'd2, b: 2'd2, c: 2'd0}; // R2
      4'h7: k = '{a: 2'd1, b: 2'd3, c: 2'd0}; // R2
      4'h8: k = '{a: 2'd3, b: 2'd0, c: 2'd1}; // R2
      4'h9: k = '{a: 2'd2, b: 2'd1, c: 2'd1}; // R3
      4'hA: k = '{a: 2'd1, b: 2'd2, c: 2'd1}; // R3
      4'hB: k = '{a: 2'd2, b: 2'd0, c: 2'd2}; // R3
      4'hC: k = '{a: 2'd1, b: 2'd1, c: 2'd2}; // R3
      4'hD: k = '{a: 2'd1, b: 2'd0, c: 2'd3}; // R3
      default: k = '{a: 2'd0, b: 2'd0, c: 2'd0};
    endcase
    return k;
  endfunction : firCoeff

  function automatic logic [RESULT_W-1:0] scale(input logic [1:0] k,
                                               input logic [SAMPLE_W-1:0] x);
    return RESULT_W'({2'b00, x} * {12'h000, k});
  endfunction : scale

  function automatic logic chanOf(input logic [SLOT_W-1:0] slot);
    return (slot == SLOT_FIFTEEN);
  endfunction : chanOf

  function automatic logic isRegAddr(input logic [ADDR_W-1:0] a,
                                     input logic [7:0] ofs);
    return (a == ADDR_W'(ofs));
  endfunction : isRegAddr

  // ==========================================================================
  // register state
  ctrl_t               ctrl   [CHAN_N];
  logic [RESULT_W-1:0] result [CHAN_N];
  logic                vflag  [CHAN_N];
  logic                seed   [CHAN_N];
  logic [ST_W-1:0]     status;
  logic [ST_W-1:0]     mask;

  logic wrCtrl7;
  logic wrCtrl15;
  logic wrStatus;
  logic wrMask;
  logic rdRes7;
  logic rdRes15;

  assign wrCtrl7  = regWr && isRegAddr(regAddr, OFS_CTRL7);
  assign wrCtrl15 = regWr && isRegAddr(regAddr, OFS_CTRL15);
  assign wrStatus = regWr && isRegAddr(regAddr, OFS_STATUS);
  assign wrMask   = regWr && isRegAddr(regAddr, OFS_MASK);
  assign rdRes7   = regRd && isRegAddr(regAddr, OFS_RES7);
  assign rdRes15  = regRd && isRegAddr(regAddr, OFS_RES15);

  // ==========================================================================
  // conversion pipeline: stage 0 reads history, stage 1 computes
  conv_t stage;
  hist_t histRd;
  hist_t next_hist;
  logic  [$bits(hist_t)-1:0] histRdBits;
  logic  accept;

  assign accept = conv.valid &&
                  (conv.slot == SLOT_SEVEN || conv.slot == SLOT_FIFTEEN); // R10

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      stage <= '0;
    end else begin
      stage       <= conv;
      stage.valid <= accept;
    end
  end

  filter_history_mem #(
    .WIDTH ($bits(hist_t)),
    .DEPTH (CHAN_N),
    .AW    (1)
  ) u_hist (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .wrEn    (stage.valid),
    .wrAddr  (chanOf(stage.slot)),
    .wrData  (next_hist),
    .rdAddr  (chanOf(conv.slot)),
    .rdData  (histRdBits)
  );

  assign histRd = hist_t'(histRdBits);

  // ==========================================================================
  // filter arithmetic
  logic                ch;
  ctrl_t               cur;
  coeff_t              k;
  hist_t               taps;
  logic [RESULT_W-1:0] firOut;
  logic [RESULT_W-1:0] iirOut;
  logic [RESULT_W-1:0] next_result;
  logic [RESULT_W-1:0] x4;
  int unsigned         sh;

  assign ch  = chanOf(stage.slot);
  assign cur = ctrl[ch];
  assign k   = firCoeff(cur.code);
  assign x4  = RESULT_W'({2'b00, stage.data} << IIR_GAIN_SHIFT);

  always_comb begin
    // seeded history makes the first output already settled
    taps = histRd;
    if (seed[ch]) begin
      taps.prev1 = stage.data;
      taps.prev2 = stage.data;
      taps.iir   = x4;
    end
  end

  // R9 R12: gain equals a+b+c, result stays within 14 bits
  assign firOut = scale(k.a, stage.data) + scale(k.b, taps.prev1) + scale(k.c, taps.prev2);

  always_comb begin
    sh = (cur.code == CODE_IIR_B) ? IIR_SHIFT_B : IIR_SHIFT_A; // R4
    // R5: state converges on four times the input
    iirOut = taps.iir - (taps.iir >> sh) + (x4 >> sh);
  end

  always_comb begin
    next_result = RESULT_W'(stage.data);
    if (cur.mode == MODE_FILTER) begin
      if (cur.code == CODE_IIR_A || cur.code == CODE_IIR_B) begin
        next_result = iirOut; // R11
      end else begin
        next_result = firOut; // R11
      end
    end
  end

  always_comb begin
    // R12: history shifts on every accepted conversion
    next_hist.prev1 = stage.data;
    next_hist.prev2 = taps.prev1;
    next_hist.iir   = iirOut;
  end

  // ==========================================================================
  // control registers and seed requests
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < CHAN_N; i++) begin
        ctrl[i] <= '{mode: MODE_RESET, code: CODE_RESET};
      end
    end else begin
      if (wrCtrl7) begin
        ctrl[0].mode <= regWrData[CTRL_MODE_LSB +: 2];
        ctrl[0].code <= regWrData[CTRL_CODE_LSB +: 4];
      end
      if (wrCtrl15) begin
        ctrl[1].mode <= regWrData[CTRL_MODE_LSB +: 2];
        ctrl[1].code <= regWrData[CTRL_CODE_LSB +: 4];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < CHAN_N; i++) begin
        seed[i] <= 1'b1;
      end
    end else begin
      for (int i = 0; i < CHAN_N; i++) begin
        if (stage.valid && ch == 1'(i)) begin
          seed[i] <= 1'b0;
        end
      end
      // R6: init request rearms seeding from the next conversion
      if (wrCtrl7 && regWrData[CTRL_INIT_BIT]) begin
        seed[0] <= 1'b1;
      end
      if (wrCtrl15 && regWrData[CTRL_INIT_BIT]) begin
        seed[1] <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // result registers and valid flags
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < CHAN_N; i++) begin
        result[i] <= '0;
      end
    end else if (stage.valid) begin
      result[ch] <= next_result; // R5 R9
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < CHAN_N; i++) begin
        vflag[i] <= 1'b0;
      end
    end else begin
      // a read clears the flag, a new result in the same cycle wins
      if (rdRes7) begin
        vflag[0] <= 1'b0;
      end
      if (rdRes15) begin
        vflag[1] <= 1'b0;
      end
      if (stage.valid) begin
        vflag[ch] <= 1'b1; // R7
      end
    end
  end

  // ==========================================================================
  // interrupt status and mask
  logic [ST_W-1:0] events;

  always_comb begin
    events = '0;
    if (stage.valid) begin
      events[ch ? ST_NEW15 : ST_NEW7] = 1'b1;
      events[ch ? ST_OVR15 : ST_OVR7] = vflag[ch];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status <= STATUS_RESET;
    end else begin
      status <= (status & ~(wrStatus ? regWrData[ST_W-1:0] : '0)) | events;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mask <= MASK_RESET;
    end else if (wrMask) begin
      mask <= regWrData[ST_W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((status & ~(wrStatus ? regWrData[ST_W-1:0] : '0)) | events)
               & (wrMask ? regWrData[ST_W-1:0] : mask));
    end
  end

  // ==========================================================================
  // read data, one cycle after the strobe
  function automatic logic [31:0] resWord(input logic [RESULT_W-1:0] r,
                                          input logic v);
    logic [31:0] w;
    w = '0;
    w[RESULT_W-1:0]           = r;
    w[RES_VALID_BIT]          = v;
    w[RES_CNT_LSB +: 2]       = REDUCTION_IDLE; // R7
    return w;
  endfunction : resWord

  function automatic logic [31:0] ctrlWord(input ctrl_t c);
    logic [31:0] w;
    w = '0;
    w[CTRL_MODE_LSB +: 2] = c.mode;
    w[CTRL_CODE_LSB +: 4] = c.code;
    return w;
  endfunction : ctrlWord

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      regRdData <= '0;
    end else if (regRd) begin
      regRdData <= '0;
      if (isRegAddr(regAddr, OFS_CTRL7)) begin
        regRdData <= ctrlWord(ctrl[0]);
      end
      if (isRegAddr(regAddr, OFS_CTRL15)) begin
        regRdData <= ctrlWord(ctrl[1]);
      end
      if (rdRes7) begin
        regRdData <= resWord(result[0], vflag[0]);
      end
      if (rdRes15) begin
        regRdData <= resWord(result[1], vflag[1]);
      end
      if (isRegAddr(regAddr, OFS_STATUS)) begin
        regRdData <= {{(32-ST_W){1'b0}}, status};
      end
      if (isRegAddr(regAddr, OFS_MASK)) begin
        regRdData <= {{(32-ST_W){1'b0}}, mask};
      end
    end else begin
      regRdData <= '0;
    end
  end

endmodule : adc_result_filter
`default_nettype wire

//--- verilog/adc_result_filter_pkg.sv
// Constants, field layouts and carrier types for the result filter stage.
// Assumes one clock and a plain register port of the surrounding system.
// Notes on behaviour
// R1 - filter mode, codes 0..4 pick FIR (2,1,0) (1,2,0) (2,0,1) (1,1,1) (1,0,2)
// R2 - filter mode, codes 5..8 pick FIR (3,1,0) (2,2,0) (1,3,0) (3,0,1)
// R3 - filter mode, codes 9..13 pick FIR (2,1,1) (1,2,1) (2,0,2) (1,1,2) (1,0,3)
// R4 - code 1110 picks IIR a=2 b=2, code 1111 picks IIR a=3 b=4
// R5 - IIR gain is four, stored result 14 bits; reader divides by four
// R6 - software initialises filter history before trusting the first outputs
// R7 - reader trusts a result only with valid flag one and reduction counter zero
// R8 - reader should wait after start-up before reading filtered results
// R9 - FIR gain equals coefficient sum, three or four, giving a 14-bit result
// R10 - filtering exists only on result slots seven and fifteen
// R11 - filter is third-order FIR or first-order IIR over successive conversions
// R12 - FIR output is a*newest + b*previous + c*one before, per conversion
package adc_result_filter_pkg;

  // ==========================================================================
  // widths
  localparam int SAMPLE_W = 12;
  localparam int RESULT_W = 14;
  localparam int SLOT_W   = 4;
  localparam int CHAN_N   = 2;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] OFS_CTRL7   = 8'h00;
  localparam logic [7:0] OFS_CTRL15  = 8'h04;
  localparam logic [7:0] OFS_RES7    = 8'h08;
  localparam logic [7:0] OFS_RES15   = 8'h0C;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  localparam logic [7:0] OFS_MASK    = 8'h14;

  // ==========================================================================
  // result slots carrying the filter
  localparam logic [3:0] SLOT_SEVEN   = 4'h7;
  localparam logic [3:0] SLOT_FIFTEEN = 4'hF;

  // ==========================================================================
  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CODE_LSB = 2;
  localparam int CTRL_INIT_BIT = 8;
  localparam logic [1:0] MODE_RESET  = 2'h0;
  localparam logic [1:0] MODE_FILTER = 2'h1;
  localparam logic [3:0] CODE_RESET  = 4'h0;
  localparam logic [3:0] CODE_IIR_A  = 4'hE;
  localparam logic [3:0] CODE_IIR_B  = 4'hF;

  // ==========================================================================
  // result register fields
  localparam int RES_VALID_BIT = 16;
  localparam int RES_CNT_LSB   = 18;
  localparam logic [1:0] REDUCTION_IDLE = 2'h0;

  // ==========================================================================
  // status and mask bits
  localparam int ST_NEW7   = 0;
  localparam int ST_NEW15  = 1;
  localparam int ST_OVR7   = 2;
  localparam int ST_OVR15  = 3;
  localparam int ST_W      = 4;
  localparam logic [ST_W-1:0] STATUS_RESET = 4'h0;
  localparam logic [ST_W-1:0] MASK_RESET   = 4'h0;

  // ==========================================================================
  // iir shifts: weight of new sample 4/b, of old state (b-1)/b
  localparam int IIR_SHIFT_A = 1;
  localparam int IIR_SHIFT_B = 2;
  localparam int IIR_GAIN_SHIFT = 2;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic                valid;
    logic [SLOT_W-1:0]   slot;
    logic [SAMPLE_W-1:0] data;
  } conv_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] prev1;
    logic [SAMPLE_W-1:0] prev2;
    logic [RESULT_W-1:0] iir;
  } hist_t;

  typedef struct packed {
    logic [1:0] a;
    logic [1:0] b;
    logic [1:0] c;
  } coeff_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [3:0] code;
  } ctrl_t;

endpackage : adc_result_filter_pkg

//--- verilog/filter_history_mem.sv
// Small history store: one word of filter taps per filtered result slot.
// Assumes one writer and one reader; read data appear one cycle after address.
`timescale 1ns/1ps
`default_nettype none
module filter_history_mem #(
  parameter int WIDTH = 38,
  parameter int DEPTH = 2,
  parameter int AW    = 1
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  // write port
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  // read port
  input  wire logic [AW-1:0]    rdAddr,
  output logic      [WIDTH-1:0] rdData
);

  // geometry the store cannot serve
  if (DEPTH < 1 || DEPTH > (1 << AW) || WIDTH < 1) begin : gBadGeometry
    $error("filter_history_mem: bad geometry");
  end

  logic [WIDTH-1:0] store [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        store[i] <= '0;
      end
    end else if (wrEn) begin
      store[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdData <= '0;
    end else begin
      rdData <= store[rdAddr];
    end
  end

endmodule : filter_history_mem
`default_nettype wire

//--- testbench/conv_source.sv
// Conversion source model: emits one-cycle conversion results on request.
// Assumes the bench spaces requests at least two cycles apart.
`timescale 1ns/1ps
`default_nettype none
module conv_source
  import adc_result_filter_pkg::*;
(
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  // request from bench
  input  wire logic                req,
  input  wire logic [SLOT_W-1:0]   reqSlot,
  input  wire logic [SAMPLE_W-1:0] reqData,
  // conversion result
  output var  conv_t               conv
);
  // ==========================================================================
  // pulse generation
  // slot and data scrambled between pulses
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      conv <= '0;
    end else if (req && !conv.valid) begin
      conv.valid <= 1'b1;
      conv.slot  <= reqSlot;
      conv.data  <= reqData;
    end else begin
      conv.valid <= 1'b0;
      conv.slot  <= ~conv.slot;
      conv.data  <= ~conv.data;
    end
  end
endmodule : conv_source
`default_nettype wire

//--- testbench/adc_result_filter_chk.sv
// Port checker for the result filter stage, bound to its top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module adc_result_filter_chk
  import adc_result_filter_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  // watched ports
  input  wire conv_t             conv,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [31:0]       regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  input  wire logic [31:0]       regRdData,
  input  wire logic              irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================================
  // helpers
  logic [7:0] a8;
  logic       c7;
  logic       acc;
  logic       rdRes7;
  logic       mapped;
  logic       maskWr;
  logic       statWr;
  logic [1:0] mode7;
  assign a8     = 8'(regAddr);
  assign c7     = conv.valid && conv.slot == SLOT_SEVEN;
  assign acc    = c7 || (conv.valid && conv.slot == SLOT_FIFTEEN);
  assign rdRes7 = regRd && a8 == OFS_RES7;
  assign mapped = a8 inside {OFS_CTRL7, OFS_CTRL15, OFS_RES7, OFS_RES15, OFS_STATUS, OFS_MASK};
  assign maskWr = regWr && a8 == OFS_MASK;
  assign statWr = regWr && (a8 == OFS_MASK || a8 == OFS_STATUS);
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      mode7 <= MODE_RESET;
    end else if (regWr && a8 == OFS_CTRL7) begin
      mode7 <= regWrData[CTRL_MODE_LSB +: 2];
    end
  end
  // ==========================================================================
  // properties
  property p_rd_idle;
    !$past(regRd) |-> regRdData == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
  property p_unmapped;
    $past(regRd && !mapped) |-> regRdData == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_res_width;
    $past(regRd && (a8 == OFS_RES7 || a8 == OFS_RES15))
      |-> regRdData[31:17] == 15'h0 && regRdData[15:14] == 2'h0;
  endproperty
  a_res_width: assert property (p_res_width) else $error("result wider than 14 bits");
  property p_init_clear;
    $past(regRd && (a8 == OFS_CTRL7 || a8 == OFS_CTRL15)) |-> !regRdData[CTRL_INIT_BIT];
  endproperty
  a_init_clear: assert property (p_init_clear) else $error("init bit reads one");
  property p_irq_cause;
    $rose(irq) |-> $past(acc) || $past(acc, 2) || $past(maskWr) || $past(maskWr, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
  property p_irq_fall;
    $fell(irq) |-> $past(statWr) || $past(statWr, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
  property p_valid_new;
    c7 ##2 rdRes7 |-> ##1 regRdData[RES_VALID_BIT]
      && regRdData[RES_CNT_LSB +: 2] == REDUCTION_IDLE;
  endproperty
  a_valid_new: assert property (p_valid_new) else $error("new result not flagged");
  property p_read_clears;
    (rdRes7 && !c7 && !$past(c7)) ##1 !c7 ##1 rdRes7 |-> ##1 !regRdData[RES_VALID_BIT];
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("valid flag not cleared");
  property p_raw;
    c7 && mode7 != MODE_FILTER ##2 rdRes7 |-> ##1 regRdData[13:0] == 14'($past(conv.data, 3));
  endproperty
  a_raw: assert property (p_raw) else $error("unfiltered result differs");
  c_read7: cover property (c7 ##2 rdRes7);
  c_irq: cover property ($rose(irq));
  c_unmapped: cover property (regRd && !mapped);
endmodule : adc_result_filter_chk
bind adc_result_filter adc_result_filter_chk #(.ADDR_W(ADDR_W)) uChk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .conv(conv), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .irq(irq));
`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the result filter stage with a reference model.
// Assumes the package, design, source model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== 32'(ex)) begin failures++; \
  $display("MISMATCH %s exp %h got %h", nm, 32'(ex), got); end end
module testbench
  import adc_result_filter_pkg::*;
;
  logic              sys_clk   = 1'b0;
  logic              sys_rst   = 1'b1;
  logic              req       = 1'b0;
  logic [3:0]        reqSlot   = 4'h0;
  logic [11:0]       reqData   = 12'h0;
  logic [7:0]        regAddr   = 8'h00;
  logic [31:0]       regWrData = 32'h0;
  logic              regWr     = 1'b0;
  logic              regRd     = 1'b0;
  logic [31:0]       regRdData;
  logic              irq;
  logic [31:0]       d;
  conv_t             conv;
  int                failures  = 0;
  int                cmp_count = 0;
  int unsigned       rs        = 28;
  int                p1[2], p2[2], iirSt[2], res[2], vf[2], armed[2], md[2], cd[2];
  int                st, msk;
  int                ca[14] = '{2, 1, 2, 1, 1, 3, 2, 1, 3, 2, 1, 2, 1, 1};
  int                cb[14] = '{1, 2, 0, 1, 0, 1, 2, 3, 0, 1, 2, 0, 1, 0};
  int                cc[14] = '{0, 0, 1, 1, 2, 0, 0, 0, 1, 1, 1, 2, 2, 3};
  logic [7:0]        addrs[8] = '{OFS_CTRL7, OFS_CTRL15, OFS_RES7, OFS_RES15,
                                  OFS_STATUS, OFS_MASK, 8'h18, 8'h40};
  adc_result_filter dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .conv(conv),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .irq(irq));
  conv_source src (.sys_clk(sys_clk), .sys_rst(sys_rst), .req(req), .reqSlot(reqSlot),
    .reqData(reqData), .conv(conv));
  always #10 sys_clk = ~sys_clk;
  // ==========================================================================
  // helpers
  function automatic int rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return int'(rs & 32'hFFF);
  endfunction : rnd
  task automatic model_reset();
    vf = '{0, 0};
    res = '{0, 0};
    md = '{0, 0};
    cd = '{0, 0};
    armed = '{1, 1};
    st = 0;
    msk = 0;
  endtask : model_reset
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= v;
    @(posedge sys_clk);
    regWr <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      if (a == (i ? OFS_CTRL15 : OFS_CTRL7)) begin
        md[i] = v[1:0];
        cd[i] = v[5:2];
        if (v[CTRL_INIT_BIT]) armed[i] = 1;
      end
    end
    if (a == OFS_STATUS) st &= ~int'(v);
    if (a == OFS_MASK) msk = int'(v[3:0]);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 v = regRdData;
  endtask : rd
  task automatic send(input logic [3:0] sl, input int x);
    int i;
    int y;
    int yi;
    i = (sl == SLOT_FIFTEEN) ? 1 : 0;
    @(posedge sys_clk);
    req     <= 1'b1;
    reqSlot <= sl;
    reqData <= 12'(x);
    @(posedge sys_clk);
    req <= 1'b0;
    @(posedge sys_clk);
    if (sl == SLOT_SEVEN || sl == SLOT_FIFTEEN) begin
      if (armed[i]) begin
        p1[i] = x;
        p2[i] = x;
        iirSt[i] = 4 * x;
        armed[i] = 0;
      end
      // iir state runs in every mode, shift picked by the code alone
      if (cd[i] == 15) yi = iirSt[i] - (iirSt[i] >> 2) + (4 * x >> 2);
      else yi = iirSt[i] - (iirSt[i] >> 1) + (4 * x >> 1);
      if (md[i] != 1) y = x;
      else if (cd[i] < 14) y = ca[cd[i]] * x + cb[cd[i]] * p1[i] + cc[cd[i]] * p2[i];
      else y = yi;
      p2[i] = p1[i];
      p1[i] = x;
      iirSt[i] = yi;
      if (vf[i]) st |= 4 << i;
      st |= 1 << i;
      vf[i] = 1;
      res[i] = y;
    end
  endtask : send
  task automatic rd_res(input int i);
    rd(i ? OFS_RES15 : OFS_RES7, d);
    `CHK("result", (vf[i] << RES_VALID_BIT) | res[i], d)
    vf[i] = 0;
    rd(i ? OFS_RES15 : OFS_RES7, d);
    `CHK("cleared", res[i], d)
    `CHK("irq", (st & msk) != 0, irq)
  endtask : rd_res
  task automatic regs_reset();
    foreach (addrs[k]) begin
      rd(addrs[k], d);
      `CHK("reset value", 0, d)
    end
  endtask : regs_reset
  task automatic irq_after(input logic [7:0] a, input logic [31:0] v);
    wr(a, v);
    repeat (2) @(posedge sys_clk);
    `CHK("irq", (st & msk) != 0, irq)
  endtask : irq_after
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  // ==========================================================================
  // sequence
  initial begin
    model_reset();
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (5) @(posedge sys_clk);
    regs_reset();
    for (int code = 0; code < 16; code++) begin
      for (int k = 0; k < 2; k++) begin
        wr(k ? OFS_CTRL15 : OFS_CTRL7, {23'h0, 1'b1, 2'h0, 4'(code), MODE_FILTER});
        rd(k ? OFS_CTRL15 : OFS_CTRL7, d);
        `CHK("control", (code << 2) | 1, d)
        repeat (4) begin
          send(k ? SLOT_FIFTEEN : SLOT_SEVEN, rnd());
          rd_res(k);
        end
      end
    end
    for (int m = 0; m < 4; m++) begin
      if (m != 1) begin
        wr(OFS_CTRL7, {26'h0, 4'h5, 2'(m)});
        send(SLOT_SEVEN, rnd());
        rd_res(0);
      end
    end
    foreach (addrs[k]) begin
      send(4'(k * 2 + 2), rnd());
      rd_res(0);
    end
    irq_after(OFS_STATUS, 32'hF);
    irq_after(OFS_MASK, 32'h1);
    send(SLOT_SEVEN, rnd());
    send(SLOT_SEVEN, rnd());
    rd(OFS_STATUS, d);
    `CHK("status", st, d)
    rd_res(0);
    irq_after(OFS_STATUS, 32'h1);
    irq_after(OFS_MASK, 32'h4);
    irq_after(OFS_STATUS, 32'h4);
    irq_after(8'h18, 32'hF);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    model_reset();
    regs_reset();
    send(SLOT_FIFTEEN, rnd());
    rd_res(1);
    end_sim();
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    failures++;
    end_sim();
  end
endmodule : testbench
`default_nettype wire
